// ---- rtl/nvx_pkg.sv ----
// Constants and types shared by the I/O expander design files
`default_nettype none
package nvx_pkg;
    // =========================================================
    // Register offsets
    localparam logic [7:0] USER_LAST          = 8'h3f;
    localparam logic [7:0] PULLUP_ENABLE_LOW  = 8'hf0;
    localparam logic [7:0] PULLUP_ENABLE_HIGH = 8'hf1;
    localparam logic [7:0] OUTPUT_CTRL_LOW    = 8'hf2;
    localparam logic [7:0] OUTPUT_CTRL_HIGH   = 8'hf3;
    localparam logic [7:0] CONFIGURATION      = 8'hf4;
    localparam logic [7:0] USER_HI_FIRST      = 8'hf5;
    localparam logic [7:0] USER_HI_LAST       = 8'hf7;
    localparam logic [7:0] PIN_STATUS_LOW     = 8'hf8;
    localparam logic [7:0] PIN_STATUS_HIGH    = 8'hf9;
    localparam logic [7:0] SRAM_FIRST         = 8'hfa;
    localparam logic [7:0] SRAM_LAST          = 8'hff;

    // =========================================================
    // Field positions and sizes
    localparam int SEE_BIT = 0;
    localparam int NPIN    = 9;
    localparam int NUSER   = 64;
    localparam int NSRAM   = 6;

    // =========================================================
    // Reset and factory values
    localparam logic [8:0] PULLUP_RST = 9'h000;
    localparam logic [8:0] CTRL_RST   = 9'h1ff;
    localparam logic [7:0] USER_RST   = 8'h00;
    localparam logic       SEE_RST    = 1'b0;
    // Upper four slave address bits, value arbitrary
    localparam logic [3:0] SLAVE_BASE = 4'ha;
    localparam logic [3:0] BITS_BYTE  = 4'h8;

    // =========================================================
    // Timing
    localparam int CLK_PERIOD_NS         = 10;
    localparam int NV_WRITE_DURATION_NS  = 10_000_000;
    localparam int NV_WRITE_CYCLES       = NV_WRITE_DURATION_NS / CLK_PERIOD_NS;
    localparam int BUSY_W                = 20;

    // =========================================================
    // Serial transfer states
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_REG, ST_WDAT,
        ST_SACK, ST_RD, ST_MACK, ST_MNXT, ST_SKIP
    } nvx_state_t;
endpackage
`default_nettype wire

// ---- rtl/nvx_scl_sampler.sv ----
// Serial data sampler running on the bus clock
`timescale 1ns/10ps
`default_nettype none
module nvx_scl_sampler (
    // Link clock and reset
    input  wire logic scl,
    input  wire logic resetn,
    // Serial data input
    input  wire logic sda_i,
    // Sampled bit and event toggle
    output logic      smp_bit,
    output logic      smp_tog
);
    typedef struct packed {
        logic bit_v;
        logic tog;
    } nvx_smp_t;

    nvx_smp_t st_ff;
    nvx_smp_t nxt_st;

    // =========================================================
    // Capture on rising clock; the toggle tells the other domain
    // Bit stays put a whole clock period, so it is read after the toggle
    always_comb begin
        nxt_st.bit_v = sda_i; // see [R19] see [R18]
        nxt_st.tog   = ~st_ff.tog;
    end

    // Bus clock may never run during reset, so this reset cannot wait for it
    always_ff @(posedge scl or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign smp_bit = st_ff.bit_v;
    assign smp_tog = st_ff.tog;
endmodule
`default_nettype wire

// ---- rtl/nvx_sync.sv ----
// Two-stage synchroniser for levels entering the system clock domain
`timescale 1ns/10ps
`default_nettype none
module nvx_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // Asynchronous level in, synchronised level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } nvx_sync_t;

    nvx_sync_t st_ff;
    nvx_sync_t nxt_st;

    // =========================================================
    // First stage feeds only the second stage
    always_comb begin
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
        if (!resetn) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    assign q = st_ff.s2;
endmodule
`default_nettype wire

// ---- rtl/nvx_top.sv ----
// Serial-bus I/O expander: slave, register map, memories and pin drive
// Behaviour
// [R1] Each pin: input, pulldown, switchable pullup
// [R2] Pullup enables at F0h and F1h
// [R3] Output control at F2h, F3h drives pulldown
// [R4] Status F8h, F9h reads actual pin levels
// [R5] Control and pullup read back programmed value
// [R6] Control and pullup are shadowed non-volatile
// [R7] Non-volatile write starts a timed write cycle
// [R8] Shadow bit clear: write both copies
// [R9] Shadow bit set: write volatile copy only
// [R10] Stored pin settings applied at power-up
// [R11] 64-byte non-volatile user memory
// [R12] Plain volatile memory locations also present
// [R13] Address pins give three address bits
// [R14] Data falling, clock high: transfer starts
// [R15] Data rising, clock high: transfer ends
// [R16] Repeated start begins a new transfer
// [R17] Master makes all clocks, starts, stops
// [R18] Master changes data only while clock low
// [R19] Data sampled on rising bus clock
// [R20] Both lines high after stop: idle
// [R21] Control bit 0 drives low, 1 releases
// [R22] Pullup bit 1 enables, high register bit 0
// [R23] Write cycle begins after the stop
// [R24] Receiver acks ninth bit; master nacks read end
// [R25] Address pins sit just above direction bit
`timescale 1ns/10ps
`default_nettype none
module nvx_top #(
    parameter int NV_CYC = nvx_pkg::NV_WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       cold_start,
    // Serial bus
    input  wire logic       scl,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // Address select pins
    input  wire logic       addr_select_bit0,
    input  wire logic       addr_select_bit1,
    input  wire logic       addr_select_bit2,
    // Expander pins
    input  wire logic [8:0] io_i,
    output logic      [8:0] io_o,
    output logic      [8:0] io_oe,
    output logic      [8:0] pullup_en,
    // Status
    output logic            bus_idle,
    output logic            nv_busy
);
    typedef struct packed {
        nvx_pkg::nvx_state_t              state;
        logic [3:0]                       cnt;
        logic [7:0]                       sr;
        logic [7:0]                       ptr;
        logic                             rw;
        logic                             sda_oe;
        logic                             nv_pend;
        logic                             busy;
        logic [nvx_pkg::BUSY_W-1:0]       busy_cnt;
        logic [nvx_pkg::NUSER-1:0][7:0]   unv;
        logic [3:1][7:0]                  uhi;
        logic [nvx_pkg::NSRAM-1:0][7:0]   sram;
        logic [8:0]                       pu_nv;
        logic [8:0]                       pu_sr;
        logic [8:0]                       ct_nv;
        logic [8:0]                       ct_sr;
        logic                             see_nv;
        logic                             see_sr;
        logic [8:0]                       pd;
        logic                             idle;
        logic                             scl_l;
        logic                             sda_l;
        logic                             tog_l;
    } nvx_top_t;

    nvx_top_t   st_ff;
    nvx_top_t   nxt_st;
    logic       smp_bit;
    logic       smp_tog;
    logic [2:0] lnk_s;
    logic [2:0] adr_s;
    logic [8:0] io_s;
    logic       scl_s;
    logic       sda_s;
    logic       tog_s;
    logic       scl_fall;
    logic       start;
    logic       stop;
    logic       bit_ev;
    logic       wr_ev;
    logic [6:0] my_addr;
    logic [7:0] rd_data;

    // =========================================================
    // Link domain and crossings
    nvx_scl_sampler u_smp (
        .scl     (scl),
        .resetn  (resetn),
        .sda_i   (sda_i),
        .smp_bit (smp_bit),
        .smp_tog (smp_tog)
    );

    nvx_sync #(.W(3)) u_lnk_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      ({scl, sda_i, smp_tog}),
        .q      (lnk_s)
    );

    nvx_sync #(.W(12)) u_pin_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      ({addr_select_bit2, addr_select_bit1, addr_select_bit0, io_i}),
        .q      ({adr_s, io_s})
    );

    assign scl_s    = lnk_s[2];
    assign sda_s    = lnk_s[1];
    assign tog_s    = lnk_s[0];
    assign scl_fall = st_ff.scl_l & ~scl_s;
    assign start    = scl_s & st_ff.scl_l & st_ff.sda_l & ~sda_s; // see [R14] see [R16]
    assign stop     = scl_s & st_ff.scl_l & ~st_ff.sda_l & sda_s; // see [R15]
    assign bit_ev   = tog_s ^ st_ff.tog_l;
    assign my_addr  = {nvx_pkg::SLAVE_BASE, adr_s}; // see [R13] see [R25]

    // =========================================================
    // Read data selection
    always_comb begin
        rd_data = 8'h00;
        case (st_ff.ptr) inside
            [8'h00 : nvx_pkg::USER_LAST]: begin
                rd_data = st_ff.unv[st_ff.ptr[5:0]]; // see [R11]
            end
            nvx_pkg::PULLUP_ENABLE_LOW: begin
                rd_data = st_ff.pu_sr[7:0]; // see [R5]
            end
            nvx_pkg::PULLUP_ENABLE_HIGH: begin
                rd_data = {7'h00, st_ff.pu_sr[8]};
            end
            nvx_pkg::OUTPUT_CTRL_LOW: begin
                rd_data = st_ff.ct_sr[7:0]; // see [R5]
            end
            nvx_pkg::OUTPUT_CTRL_HIGH: begin
                rd_data = {7'h00, st_ff.ct_sr[8]};
            end
            nvx_pkg::CONFIGURATION: begin
                rd_data = {7'h00, st_ff.see_sr};
            end
            [nvx_pkg::USER_HI_FIRST : nvx_pkg::USER_HI_LAST]: begin
                rd_data = st_ff.uhi[st_ff.ptr[1:0]];
            end
            nvx_pkg::PIN_STATUS_LOW: begin
                rd_data = io_s[7:0]; // see [R4]
            end
            nvx_pkg::PIN_STATUS_HIGH: begin
                rd_data = {7'h00, io_s[8]}; // see [R4]
            end
            [nvx_pkg::SRAM_FIRST : nvx_pkg::SRAM_LAST]: begin
                rd_data = st_ff.sram[3'(st_ff.ptr[2:0] - 3'h2)]; // see [R12]
            end
            default: begin
                rd_data = 8'h00;
            end
        endcase
    end

    // =========================================================
    // Transfer sequencing, register writes and write timer
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.scl_l = scl_s;
        nxt_st.sda_l = sda_s;
        nxt_st.tog_l = tog_s;
        wr_ev        = 1'b0;

        if (st_ff.busy) begin
            if (st_ff.busy_cnt == '0) begin
                nxt_st.busy = 1'b0;
            end else begin
                nxt_st.busy_cnt = st_ff.busy_cnt - 1'b1;
            end
        end

        case (st_ff.state)
            nvx_pkg::ST_ADDR, nvx_pkg::ST_REG, nvx_pkg::ST_WDAT: begin
                if (bit_ev && st_ff.cnt < nvx_pkg::BITS_BYTE) begin
                    nxt_st.sr  = {st_ff.sr[6:0], smp_bit}; // see [R19]
                    nxt_st.cnt = st_ff.cnt + 4'h1;
                end else if (scl_fall && st_ff.cnt == nvx_pkg::BITS_BYTE) begin
                    nxt_st.cnt = 4'h0;
                    if (st_ff.state == nvx_pkg::ST_ADDR) begin
                        // Busy device stays silent so the master can poll for the end
                        if (st_ff.sr[7:1] == my_addr && !st_ff.busy) begin // see [R25]
                            nxt_st.sda_oe = 1'b1; // see [R24]
                            nxt_st.rw     = st_ff.sr[0];
                            nxt_st.state  = nvx_pkg::ST_AACK;
                        end else begin
                            nxt_st.state = nvx_pkg::ST_SKIP;
                        end
                    end else begin
                        nxt_st.sda_oe = 1'b1; // see [R24]
                        nxt_st.state  = nvx_pkg::ST_SACK;
                        if (st_ff.state == nvx_pkg::ST_REG) begin
                            nxt_st.ptr = st_ff.sr;
                        end else begin
                            wr_ev      = 1'b1;
                            nxt_st.ptr = st_ff.ptr + 8'h01;
                        end
                    end
                end
            end
            nvx_pkg::ST_SACK: begin
                if (scl_fall) begin
                    nxt_st.sda_oe = 1'b0;
                    nxt_st.state  = nvx_pkg::ST_WDAT;
                end
            end
            nvx_pkg::ST_AACK, nvx_pkg::ST_MNXT: begin
                if (scl_fall) begin
                    if (st_ff.state == nvx_pkg::ST_MNXT || st_ff.rw) begin
                        nxt_st.sr     = rd_data;
                        nxt_st.ptr    = st_ff.ptr + 8'h01;
                        nxt_st.sda_oe = ~rd_data[7];
                        nxt_st.state  = nvx_pkg::ST_RD;
                    end else begin
                        nxt_st.sda_oe = 1'b0;
                        nxt_st.state  = nvx_pkg::ST_REG;
                    end
                end
            end
            nvx_pkg::ST_RD: begin
                if (bit_ev) begin
                    nxt_st.cnt = st_ff.cnt + 4'h1;
                end else if (scl_fall) begin
                    if (st_ff.cnt == nvx_pkg::BITS_BYTE) begin
                        nxt_st.sda_oe = 1'b0;
                        nxt_st.cnt    = 4'h0;
                        nxt_st.state  = nvx_pkg::ST_MACK;
                    end else begin
                        nxt_st.sr     = {st_ff.sr[6:0], 1'b0};
                        nxt_st.sda_oe = ~st_ff.sr[6];
                    end
                end
            end
            nvx_pkg::ST_MACK: begin
                if (bit_ev) begin
                    // A not-acknowledge ends the read
                    nxt_st.state = smp_bit ? nvx_pkg::ST_SKIP : nvx_pkg::ST_MNXT; // see [R24]
                end
            end
            default: begin
                nxt_st.state = st_ff.state;
            end
        endcase

        if (wr_ev) begin
            case (st_ff.ptr) inside
                [8'h00 : nvx_pkg::USER_LAST]: begin
                    nxt_st.unv[st_ff.ptr[5:0]] = st_ff.sr; // see [R11]
                    nxt_st.nv_pend             = 1'b1; // see [R7]
                end
                nvx_pkg::PULLUP_ENABLE_LOW, nvx_pkg::PULLUP_ENABLE_HIGH: begin
                    if (st_ff.ptr[0]) begin
                        nxt_st.pu_sr[8] = st_ff.sr[0]; // see [R2] see [R22]
                    end else begin
                        nxt_st.pu_sr[7:0] = st_ff.sr; // see [R2]
                    end
                    if (!st_ff.see_sr) begin
                        nxt_st.pu_nv   = nxt_st.pu_sr; // see [R6] see [R8]
                        nxt_st.nv_pend = 1'b1;
                    end
                end
                nvx_pkg::OUTPUT_CTRL_LOW, nvx_pkg::OUTPUT_CTRL_HIGH: begin
                    if (st_ff.ptr[0]) begin
                        nxt_st.ct_sr[8] = st_ff.sr[0]; // see [R3]
                    end else begin
                        nxt_st.ct_sr[7:0] = st_ff.sr; // see [R3]
                    end
                    if (!st_ff.see_sr) begin
                        nxt_st.ct_nv   = nxt_st.ct_sr; // see [R6] see [R8]
                        nxt_st.nv_pend = 1'b1;
                    end
                end
                nvx_pkg::CONFIGURATION: begin
                    nxt_st.see_sr = st_ff.sr[nvx_pkg::SEE_BIT];
                    if (!st_ff.see_sr) begin
                        nxt_st.see_nv  = st_ff.sr[nvx_pkg::SEE_BIT]; // see [R8]
                        nxt_st.nv_pend = 1'b1;
                    end
                end
                [nvx_pkg::USER_HI_FIRST : nvx_pkg::USER_HI_LAST]: begin
                    nxt_st.uhi[st_ff.ptr[1:0]] = st_ff.sr;
                    nxt_st.nv_pend             = 1'b1; // see [R7]
                end
                [nvx_pkg::SRAM_FIRST : nvx_pkg::SRAM_LAST]: begin
                    nxt_st.sram[3'(st_ff.ptr[2:0] - 3'h2)] = st_ff.sr; // see [R12]
                end
                default: begin
                    nxt_st.nv_pend = nxt_st.nv_pend;
                end
            endcase
        end

        if (start) begin
            nxt_st.state  = nvx_pkg::ST_ADDR; // see [R14] see [R16]
            nxt_st.cnt    = 4'h0;
            nxt_st.sda_oe = 1'b0;
        end
        if (stop) begin
            nxt_st.state  = nvx_pkg::ST_IDLE; // see [R15]
            nxt_st.sda_oe = 1'b0;
            if (st_ff.nv_pend) begin
                // Timed write waits for the stop; skipped writes never set pend
                nxt_st.nv_pend  = 1'b0; // see [R23] see [R9]
                nxt_st.busy     = 1'b1; // see [R7]
                nxt_st.busy_cnt = nvx_pkg::BUSY_W'(NV_CYC - 1);
            end
        end

        if (!resetn) begin
            nxt_st.state    = nvx_pkg::ST_IDLE;
            nxt_st.cnt      = 4'h0;
            nxt_st.sr       = 8'h00;
            nxt_st.ptr      = 8'h00;
            nxt_st.rw       = 1'b0;
            nxt_st.sda_oe   = 1'b0;
            nxt_st.nv_pend  = 1'b0;
            nxt_st.busy     = 1'b0;
            nxt_st.busy_cnt = '0;
            nxt_st.sram     = '0;
            // Non-volatile copies survive a warm reset
            if (cold_start) begin
                nxt_st.unv    = {nvx_pkg::NUSER{nvx_pkg::USER_RST}};
                nxt_st.uhi    = {3{nvx_pkg::USER_RST}};
                nxt_st.pu_nv  = nvx_pkg::PULLUP_RST;
                nxt_st.ct_nv  = nvx_pkg::CTRL_RST;
                nxt_st.see_nv = nvx_pkg::SEE_RST;
            end
            nxt_st.pu_sr = nxt_st.pu_nv; // see [R10]
            nxt_st.ct_sr = nxt_st.ct_nv; // see [R10]
            nxt_st.see_sr = nxt_st.see_nv;
        end

        nxt_st.pd   = ~nxt_st.ct_sr; // see [R21] see [R1]
        nxt_st.idle = (nxt_st.state == nvx_pkg::ST_IDLE) & scl_s & sda_s; // see [R20]
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    // =========================================================
    // Outputs; pins only ever pull low
    assign sda_o     = 1'b0;
    assign sda_oe    = st_ff.sda_oe;
    assign io_o      = 9'h000;
    assign io_oe     = st_ff.pd; // see [R1]
    assign pullup_en = st_ff.pu_sr; // see [R22]
    assign bus_idle  = st_ff.idle;
    assign nv_busy   = st_ff.busy;

    // =========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_start_addr: assert property (start |=> st_ff.state == nvx_pkg::ST_ADDR // see [R14]
        && st_ff.cnt == 4'h0) else $error("start did not open address phase");
    a_stop_idle: assert property (stop |=> st_ff.state == nvx_pkg::ST_IDLE // see [R15]
        && !sda_oe ##1 (bus_idle || !scl_s || !sda_s)) else $error("stop did not end transfer");
    a_rep_start: assert property ((start && st_ff.state != nvx_pkg::ST_IDLE) // see [R16]
        |=> st_ff.state == nvx_pkg::ST_ADDR) else $error("repeated start ignored");
    a_sample_rise: assert property ((bit_ev && st_ff.state == nvx_pkg::ST_ADDR // see [R19]
        && st_ff.cnt < 4'h8 && !start && !stop) |=> st_ff.sr[0] == $past(smp_bit))
        else $error("bit not shifted in");
    a_addr_ack: assert property ((scl_fall && st_ff.state == nvx_pkg::ST_ADDR // see [R24]
        && st_ff.cnt == 4'h8 && st_ff.sr[7:1] == my_addr && !st_ff.busy && !stop)
        |=> sda_oe) else $error("own address not acknowledged");
    a_nv_after: assert property ($rose(st_ff.busy) |-> $past(stop)) // see [R23]
        else $error("write cycle began without stop");
    a_see_sram: assert property ((wr_ev && st_ff.see_sr // see [R9]
        && st_ff.ptr == nvx_pkg::OUTPUT_CTRL_LOW) |=> st_ff.ct_nv == $past(st_ff.ct_nv)
        && st_ff.ct_sr[7:0] == $past(st_ff.sr)) else $error("shadow write reached store");
    a_see_both: assert property ((wr_ev && !st_ff.see_sr // see [R8]
        && st_ff.ptr == nvx_pkg::PULLUP_ENABLE_LOW) |=> st_ff.pu_nv[7:0] == $past(st_ff.sr)
        && st_ff.nv_pend) else $error("store copy not written");
    a_power_up: assert property ($rose(resetn) |-> st_ff.ct_sr == st_ff.ct_nv // see [R10]
        && io_oe == ~st_ff.ct_nv && pullup_en == st_ff.pu_nv)
        else $error("stored pin settings not applied");
    a_status_rd: assert property ((scl_fall && st_ff.state == nvx_pkg::ST_AACK // see [R4]
        && st_ff.rw && st_ff.ptr == nvx_pkg::PIN_STATUS_LOW && !start && !stop)
        |=> st_ff.sr == $past(io_s[7:0])) else $error("status not pin level");
endmodule
`default_nettype wire

// ---- test/nvx_bus_master.sv ----
// Behavioural serial-bus master that drives the expander
`timescale 1ns/10ps
`default_nettype none
module nvx_bus_master (
    // Bus lines, pull is high while the master holds data low
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    localparam realtime Q = 31.25;
    // Clock rests high between frames, data released to its pull-up
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // ========================================
    // Frame conditions
    task automatic start();
        #(Q) sda_pull = 1'b0;
        #(Q) scl = 1'b1;
        #(2*Q) sda_pull = 1'b1;
        #(2*Q) scl = 1'b0;
    endtask
    task automatic stop();
        #(Q) sda_pull = 1'b1;
        #(Q) scl = 1'b1;
        #(2*Q) sda_pull = 1'b0;
        #(2*Q);
    endtask
    // ========================================
    // Eight bits of d then m; data moves only while the clock is low
    task automatic xfer(input logic [7:0] d, input logic m, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            #(Q) sda_pull = (i > 0) ? ~d[i-1] : ~m;
            #(Q) scl = 1'b1;
            r[i] = sda;
            #(2*Q) scl = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- test/nvx_top_tb.sv ----
// Self-checking bench for the serial-bus I/O expander
`timescale 1ns/10ps
`default_nettype none
module nvx_top_tb;
    // ========================================
    // Stimulus and observed signals
    logic       clk = 1'b0;
    logic       resetn, cold_start, scl, sda_pull, sda, sda_o, sda_oe;
    logic       bus_idle, nv_busy;
    logic [2:0] asel;
    logic [8:0] io_v, io_o, io_oe, pullup_en, obs_val, exp_v, pu, ct, c2;
    logic [7:0] dev_w;
    logic [15:0] seed;
    logic [8:0] exp_q[$];
    int         mismatches = 0, tests_run = 0, cyc = 0;
    event       obs;
    always #5 clk = ~clk;
    // Open-drain data line with pull-up
    assign sda = ~(sda_pull | (sda_oe & ~sda_o));
    // Long write cycle shortened, still longer than one byte on the bus
    nvx_top #(.NV_CYC(400)) u_dut (.clk(clk), .resetn(resetn), .cold_start(cold_start),
        .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .addr_select_bit0(asel[0]), .addr_select_bit1(asel[1]), .addr_select_bit2(asel[2]),
        .io_i(io_v), .io_o(io_o), .io_oe(io_oe), .pullup_en(pullup_en),
        .bus_idle(bus_idle), .nv_busy(nv_busy));
    nvx_bus_master u_m (.scl(scl), .sda_pull(sda_pull), .sda(sda));
    // ========================================
    // Watcher and helpers
    always @(obs) begin
        exp_v = exp_q.pop_front();
        tests_run++;
        if (obs_val !== exp_v) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, obs_val, exp_v);
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [8:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[8:0];
    endfunction
    task automatic chk(input logic [8:0] e, input logic [8:0] g);
        exp_q.push_back(e);
        obs_val = g;
        -> obs;
        #1;
    endtask
    task automatic bx(input logic [7:0] b, input logic m, input logic [8:0] e);
        logic [8:0] r;
        u_m.xfer(b, m, r);
        chk(e, r);
    endtask
    task automatic wr(input logic [7:0] p, input logic [15:0] d, input logic bz);
        u_m.start();
        bx(dev_w, 1'b1, {dev_w, 1'b0});
        bx(p, 1'b1, {p, 1'b0});
        bx(d[15:8], 1'b1, {d[15:8], 1'b0});
        bx(d[7:0], 1'b1, {d[7:0], 1'b0});
        chk(9'h000, {7'h00, bus_idle, nv_busy});
        u_m.stop();
        repeat (6) @(posedge clk);
        #1;
        chk({7'h01, bz}, {7'h00, bus_idle, nv_busy});
    endtask
    task automatic rd(input logic [7:0] p, input logic [15:0] e);
        u_m.start();
        bx(dev_w, 1'b1, {dev_w, 1'b0});
        bx(p, 1'b1, {p, 1'b0});
        u_m.start();
        bx(dev_w | 8'h01, 1'b1, {dev_w | 8'h01, 1'b0});
        bx(8'hff, 1'b0, {e[15:8], 1'b0});
        bx(8'hff, 1'b1, {e[7:0], 1'b1});
        u_m.stop();
    endtask
    task automatic wait_nv();
        for (int k = 0; k < 1000 && nv_busy !== 1'b0; k++) @(posedge clk);
        #1;
        chk(9'h000, {8'h00, nv_busy});
    endtask
    task automatic boot(input logic cold);
        resetn = 1'b0;
        cold_start = cold;
        repeat (5) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (6) @(posedge clk);
        #1;
    endtask
    // ========================================
    // Main sequence
    initial begin
        seed = 16'h5ccf;
        pu = rnd();
        asel = pu[2:0];
        io_v = rnd();
        dev_w = {nvx_pkg::SLAVE_BASE, asel, 1'b0};
        // Reset falls after time zero so the bus-clock flops see its edge
        @(posedge clk);
        #1;
        boot(1'b1);
        chk(9'h000, io_oe);
        chk(9'h000, pullup_en);
        chk(9'h000, io_o);
        chk(9'h001, {8'h00, bus_idle});
        u_m.start();
        bx(dev_w ^ 8'h04, 1'b1, {dev_w ^ 8'h04, 1'b1});
        u_m.stop();
        pu = rnd();
        ct = rnd();
        wr(8'hf0, {pu[7:0], ct[7:1], pu[8]}, 1'b1);
        u_m.start();
        bx(dev_w, 1'b1, {dev_w, 1'b1});
        u_m.stop();
        wait_nv();
        wr(8'hf2, {ct[7:0], pu[7:1], ct[8]}, 1'b1);
        wait_nv();
        chk(~ct, io_oe);
        chk(pu, pullup_en);
        rd(8'hf0, {pu[7:0], 7'h00, pu[8]});
        rd(8'hf2, {ct[7:0], 7'h00, ct[8]});
        rd(8'hf8, {io_v[7:0], 7'h00, io_v[8]});
        wr(8'hff, {pu[7:0], ct[7:0]}, 1'b1);
        wait_nv();
        rd(8'hff, {pu[7:0], ct[7:0]});
        wr(8'h40, {ct[7:0], pu[7:0]}, 1'b0);
        rd(8'h40, 16'h0000);
        wr(8'hf4, 16'h0100, 1'b1);
        wait_nv();
        c2 = rnd();
        wr(8'hf2, {c2[7:0], 7'h00, c2[8]}, 1'b0);
        chk(~c2, io_oe);
        @(posedge clk);
        #1;
        boot(1'b0);
        chk(~ct, io_oe);
        chk(pu, pullup_en);
        give_verdict();
    end
endmodule
`default_nettype wire
